// [cbs_map.svh]
// register offsets, field positions, reset values and protocol constants
`ifndef CBS_MAP_SVH
`define CBS_MAP_SVH

// slave address: fixed upper nibble, low three bits from strap
`define CBS_ADDR_HI        4'hD
// register indexes
`define CBS_REG_OUT_EN     8'h00
`define CBS_REG_PLL        8'h01
// output enable register: enable bits for outputs 3..0
`define CBS_OUT3_EN_BIT    6
`define CBS_OUT2_EN_BIT    4
`define CBS_OUT1_EN_BIT    3
`define CBS_OUT0_EN_BIT    1
`define CBS_OUT_EN_RESET   8'h5A
`define CBS_OUT_EN_WMASK   8'h5A
// pll mode and swing register, low six bits are stored
`define CBS_PLL_SW_SEL_BIT 5
`define CBS_PLL_SOFT_HI    4
`define CBS_PLL_SOFT_LO    3
`define CBS_SWING_HI       1
`define CBS_SWING_LO       0
`define CBS_PLL_RESET      6'h06
`define CBS_PLL_WMASK      6'h3B
// byte count returned at the head of a block read
`define CBS_READ_COUNT     8'h02
// bits per byte on the link
`define CBS_BYTE_BITS      4'h8
// sequence numbers of bytes inside a transaction
`define CBS_BYTE_ADDR      2'h0
`define CBS_BYTE_INDEX     2'h1
`define CBS_BYTE_COUNT     2'h2
`define CBS_BYTE_DATA      2'h3

`endif

// [cbs_pkg.sv]
// types shared by the clock buffer control block
package cbs_pkg;

  // link engine states
  typedef enum logic [2:0] {
    CBS_IDLE,   // waiting for a start
    CBS_RECV,   // shifting in a byte
    CBS_ACK,    // holding the acknowledge low
    CBS_SEND,   // shifting out a byte
    CBS_MACK    // sampling the master acknowledge
  } cbs_state_t;

  // two-bit pll mode code
  typedef logic [1:0] cbs_mode_t;

endpackage : cbs_pkg

// [cbs_smbus_host.sv]
// smbus host model acting as bus master
module cbs_smbus_host (
  output logic      scl,      // link clock, high outside frames
  output logic      sda_low,  // host pulls data low
  input  wire logic sda       // resolved data line, pulled up
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start from idle, or repeated start from clock low
  task automatic start();
    if (!scl) begin
      #80 sda_low = 1'b0;
      #80 scl = 1'b1;
      #160;
    end
    sda_low = 1'b1;
    #160 scl = 1'b0;
  endtask : start
  // stop, allowed after any whole byte
  task automatic stop();
    #80 sda_low = 1'b1;
    #80 scl = 1'b1;
    #160 sda_low = 1'b0;
    #160;
  endtask : stop
  // one bit out, line sampled mid clock high
  task automatic bit_io(input logic b, output logic s);
    #80 sda_low = ~b;
    #80 scl = 1'b1;
    #80 s = sda;
    #80 scl = 1'b0;
  endtask : bit_io
  // byte out msb first, then device ack
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : put_byte
  // byte in, then ack, or nack on the last
  task automatic get_byte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask : get_byte
endmodule : cbs_smbus_host

// [cbs_smbus_props.sv]
// port assertions for the smbus control block
module cbs_smbus_props (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               ce,
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic               sda_out,
  input wire logic               sda_oe,
  input wire logic [2:0]         address_strap_pin,
  input wire cbs_pkg::cbs_mode_t bandwidth_strap_pin,
  input wire logic [3:0]         out_enable_pin_n,
  input wire logic [3:0]         out_run,
  input wire cbs_pkg::cbs_mode_t pll_mode,
  input wire logic [1:0]         swing_select
);
  import cbs_pkg::*;
  logic [7:0] age_reg;   // cycles since reset or any data drive
  logic [7:0] age_next;  // next age, saturating
  // age counter, cleared by reset or any drive
  always_comb begin
    age_next = (age_reg == 8'hFF) ? age_reg : age_reg + 8'h01;
    if (rst || sda_oe) begin
      age_next = 8'h00;
    end
  end
  always_ff @(posedge clk_sys) begin
    age_reg <= age_next;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_drive_low; sda_out == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data drive value not low");
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed with clock high");
  property p_oe_late; $fell(scl_in) |-> $stable(sda_oe)[*2]; endproperty
  a_oe_late: assert property (p_oe_late)
    else $error("data drive moved before synchroniser delay");
  property p_ack_hold; $rose(sda_oe) |-> sda_oe[*4]; endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("low drive too short");
  property p_power_run; $fell(rst) |-> ##6 (out_run == ~out_enable_pin_n); endproperty
  a_power_run: assert property (p_power_run)
    else $error("enables not all set after reset");
  property p_power_mode;
    $fell(rst) |-> ##3 (swing_select == 2'h2 && pll_mode == bandwidth_strap_pin);
  endproperty
  a_power_mode: assert property (p_power_mode)
    else $error("mode or swing wrong after reset");
  property p_park;
    $stable(out_enable_pin_n)[*6] |-> (out_run & out_enable_pin_n) == 4'h0;
  endproperty
  a_park: assert property (p_park)
    else $error("output runs with its pin high");
  property p_bus_only; $changed({pll_mode, swing_select}) |-> age_reg < 8'h18; endproperty
  a_bus_only: assert property (p_bus_only)
    else $error("mode or swing changed without a write");
endmodule : cbs_smbus_props

bind cbs_smbus_top cbs_smbus_props props_u (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pin(address_strap_pin),
  .bandwidth_strap_pin(bandwidth_strap_pin), .out_enable_pin_n(out_enable_pin_n),
  .out_run(out_run), .pll_mode(pll_mode), .swing_select(swing_select));

// [cbs_smbus_top.sv]
// smbus slave holding the output enable and pll mode / swing registers
`include "cbs_map.svh"

// How it works
// [RULE_01] slave only, block read and write
// [RULE_02] stop after any byte ends cleanly
// [RULE_03] address 1101 plus three strap bits
// [RULE_04] write: index, count, data; all acked
// [RULE_05] read: index, restart, count, then data
// [RULE_06] byte 0 holds four enables, reset one
// [RULE_07] cleared enable overrides pin, parks output
// [RULE_08] byte 1 bits 7:6 read latched strap
// [RULE_09] bit 5 picks strap or software mode
// [RULE_10] bits 4:3 software mode, reset zero
// [RULE_11] bits 1:0 swing, reset binary 10
// [RULE_12] software mode ignored unless bit 5 set
// [RULE_13] index steps after every data byte
// [RULE_14] reserved and read-only bits ignore writes
module cbs_smbus_top (
  input  wire logic             clk_sys,             // system clock, 25 MHz
  input  wire logic             rst,                 // synchronous reset
  input  wire logic             ce,                  // clock enable
  input  wire logic             scl_in,              // smbus clock pin level
  input  wire logic             sda_in,              // smbus data pin level
  output logic                  sda_out,             // data drive value, always low
  output logic                  sda_oe,              // high while pulling data low
  input  wire logic [2:0]       address_strap_pin,   // low address bits strap
  input  wire cbs_pkg::cbs_mode_t bandwidth_strap_pin, // pll mode strap
  input  wire logic [3:0]       out_enable_pin_n,    // per-output enable pins
  output logic [3:0]            out_run,             // output running, else parked
  output cbs_pkg::cbs_mode_t    pll_mode,            // effective pll mode
  output logic [1:0]            swing_select         // output swing code
);
  import cbs_pkg::*;

  logic       scl_s;     // synchronised clock
  logic       sda_s;     // synchronised data
  logic [2:0] adr_s;     // synchronised address strap
  cbs_mode_t  bw_s;      // synchronised bandwidth strap
  logic [3:0] oen_s;     // synchronised enable pins

  // all pins cross into the system clock through two flops
  cbs_sync #(.WIDTH(11)) u_sync (
    .clk_sys (clk_sys),
    .ce      (ce),
    .d       ({scl_in, sda_in, address_strap_pin, bandwidth_strap_pin, out_enable_pin_n}),
    .q       ({scl_s, sda_s, adr_s, bw_s, oen_s})
  );

  // link engine state
  cbs_state_t st_reg,    st_next;     // engine state
  logic [3:0] bit_reg,   bit_next;    // bits shifted in this byte
  logic [7:0] sh_reg,    sh_next;     // shift register
  logic [1:0] seq_reg,   seq_next;    // byte position in transaction
  logic       rd_reg,    rd_next;     // read direction
  logic       mack_reg,  mack_next;   // master acked last byte
  logic [7:0] idx_reg,   idx_next;    // register index
  logic       oe_reg,    oe_next;     // data pull-down
  logic       scl_p_reg, scl_p_next;  // previous clock level
  logic       sda_p_reg, sda_p_next;  // previous data level
  // register file and straps
  logic [7:0] en_reg,    en_next;     // output enable register
  logic [5:0] pll_reg,   pll_next;    // pll mode / swing stored bits
  cbs_mode_t  bwl_reg,   bwl_next;    // latched bandwidth strap
  logic [2:0] adl_reg,   adl_next;    // latched address strap
  logic       lat_reg,   lat_next;    // straps have been caught
  // output flops
  logic [3:0] run_reg,   run_next;    // running outputs
  cbs_mode_t  mode_reg,  mode_next;   // effective pll mode
  logic [1:0] swg_reg,   swg_next;    // swing code

  logic scl_rise;   // clock rising edge
  logic scl_fall;   // clock falling edge
  logic start_det;  // start or repeated start
  logic stop_det;   // stop

  // bus condition detection on synchronised levels
  always_comb begin
    scl_rise  = scl_s & ~scl_p_reg;
    scl_fall  = ~scl_s & scl_p_reg;
    start_det = scl_s & scl_p_reg & sda_p_reg & ~sda_s;
    stop_det  = scl_s & scl_p_reg & ~sda_p_reg & sda_s;
  end

  // readback of a register location
  function automatic logic [7:0] rd_byte(input logic [7:0] i, input logic [7:0] en,
                                         input logic [5:0] pl, input cbs_mode_t bw);
    logic [7:0] v;
    v = 8'h00;
    if (i == `CBS_REG_OUT_EN) begin
      v = en;
    end else if (i == `CBS_REG_PLL) begin
      v = {bw, pl}; // RULE_08
    end
    return v;
  endfunction : rd_byte

  // link engine and register writes
  always_comb begin
    logic [7:0] b;
    logic [7:0] nb;
    b          = sh_reg;
    nb         = 8'h00;
    st_next    = st_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    seq_next   = seq_reg;
    rd_next    = rd_reg;
    mack_next  = mack_reg;
    idx_next   = idx_reg;
    oe_next    = oe_reg;
    en_next    = en_reg;
    pll_next   = pll_reg;
    scl_p_next = scl_s;
    sda_p_next = sda_s;
    if (start_det) begin
      // start or restart: new address byte, index kept
      st_next  = CBS_RECV;
      bit_next = 4'h0;
      seq_next = `CBS_BYTE_ADDR;
      oe_next  = 1'b0;
    end else if (stop_det) begin
      // stop after any byte just ends the transfer
      st_next = CBS_IDLE; // RULE_02
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        CBS_IDLE: begin
          // ignore traffic until a start
          oe_next = 1'b0;
        end
        CBS_RECV: begin
          if (scl_rise) begin
            // shift in msb first
            sh_next  = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == `CBS_BYTE_BITS) begin
            bit_next = 4'h0;
            st_next  = CBS_ACK;
            oe_next  = 1'b1; // RULE_04
            unique case (seq_reg)
              `CBS_BYTE_ADDR: begin
                if (b[7:1] == {`CBS_ADDR_HI, adl_reg}) begin // RULE_03
                  rd_next  = b[0]; // RULE_01
                  seq_next = `CBS_BYTE_INDEX;
                end else begin
                  // not our address: stay off the bus
                  st_next = CBS_IDLE;
                  oe_next = 1'b0;
                end
              end
              `CBS_BYTE_INDEX: begin
                idx_next = b; // RULE_04
                seq_next = `CBS_BYTE_COUNT;
              end
              `CBS_BYTE_COUNT: begin
                // count taken, stop ends the burst
                seq_next = `CBS_BYTE_DATA;
              end
              `CBS_BYTE_DATA: begin
                if (idx_reg == `CBS_REG_OUT_EN) begin
                  en_next = (b & `CBS_OUT_EN_WMASK) | (en_reg & ~`CBS_OUT_EN_WMASK); // RULE_14
                end else if (idx_reg == `CBS_REG_PLL) begin
                  pll_next = (b[5:0] & `CBS_PLL_WMASK) | (pll_reg & ~`CBS_PLL_WMASK); // RULE_14
                end
                idx_next = idx_reg + 8'h01; // RULE_13
              end
            endcase
          end
        end
        CBS_ACK: begin
          if (scl_fall) begin
            if (rd_reg) begin
              // read: count byte goes out first
              nb       = `CBS_READ_COUNT;
              sh_next  = nb; // RULE_05
              oe_next  = ~nb[7];
              bit_next = 4'h0;
              st_next  = CBS_SEND;
            end else begin
              oe_next = 1'b0;
              st_next = CBS_RECV;
            end
          end
        end
        CBS_SEND: begin
          if (scl_rise) begin
            bit_next = bit_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_reg == `CBS_BYTE_BITS) begin
              // release for the master acknowledge
              oe_next  = 1'b0;
              bit_next = 4'h0;
              st_next  = CBS_MACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        CBS_MACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              // ack: next data byte, index steps
              nb       = rd_byte(idx_reg, en_reg, pll_reg, bwl_reg); // RULE_05
              sh_next  = nb;
              oe_next  = ~nb[7];
              idx_next = idx_reg + 8'h01; // RULE_13
              st_next  = CBS_SEND;
            end else begin
              // nack ends the read, wait for stop
              st_next = CBS_IDLE; // RULE_05
            end
          end
        end
      endcase
    end
  end

  // strap latch and output decode
  always_comb begin
    adl_next  = adl_reg;
    bwl_next  = bwl_reg;
    lat_next  = lat_reg;
    if (!lat_reg) begin
      // catch straps once after reset release
      adl_next = adr_s; // RULE_03
      bwl_next = bw_s;  // RULE_08
      lat_next = 1'b1;
    end
    // cleared enable bit overrides pin, output parked low/low
    run_next = {en_reg[`CBS_OUT3_EN_BIT], en_reg[`CBS_OUT2_EN_BIT],
                en_reg[`CBS_OUT1_EN_BIT], en_reg[`CBS_OUT0_EN_BIT]} & ~oen_s; // RULE_07
    // software mode only when select bit set
    mode_next = pll_reg[`CBS_PLL_SW_SEL_BIT] ?
                pll_reg[`CBS_PLL_SOFT_HI:`CBS_PLL_SOFT_LO] : bwl_reg; // RULE_09 RULE_12
    swg_next  = pll_reg[`CBS_SWING_HI:`CBS_SWING_LO]; // RULE_11
  end

  // register all state, frozen while ce low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg    <= CBS_IDLE;
      bit_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      seq_reg   <= `CBS_BYTE_ADDR;
      rd_reg    <= 1'b0;
      mack_reg  <= 1'b0;
      idx_reg   <= 8'h00;
      oe_reg    <= 1'b0;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
      en_reg    <= `CBS_OUT_EN_RESET; // RULE_06
      pll_reg   <= `CBS_PLL_RESET;    // RULE_10 RULE_11
      bwl_reg   <= 2'h0;
      adl_reg   <= 3'h0;
      lat_reg   <= 1'b0;
      run_reg   <= 4'h0;
      mode_reg  <= 2'h0;
      swg_reg   <= 2'h0;
    end else if (ce) begin
      st_reg    <= st_next;
      bit_reg   <= bit_next;
      sh_reg    <= sh_next;
      seq_reg   <= seq_next;
      rd_reg    <= rd_next;
      mack_reg  <= mack_next;
      idx_reg   <= idx_next;
      oe_reg    <= oe_next;
      scl_p_reg <= scl_p_next;
      sda_p_reg <= sda_p_next;
      en_reg    <= en_next;
      pll_reg   <= pll_next;
      bwl_reg   <= bwl_next;
      adl_reg   <= adl_next;
      lat_reg   <= lat_next;
      run_reg   <= run_next;
      mode_reg  <= mode_next;
      swg_reg   <= swg_next;
    end
  end

  // outputs straight from flops; open-drain data only ever pulls low
  always_comb begin
    sda_out      = 1'b0;
    sda_oe       = oe_reg;
    out_run      = run_reg;
    pll_mode     = mode_reg;
    swing_select = swg_reg;
  end

endmodule : cbs_smbus_top

// [cbs_sync.sv]
// two-flop synchroniser for inputs from outside the clock domain
module cbs_sync #(
  parameter int WIDTH = 1  // number of bits synchronised
) (
  input  wire logic             clk_sys,  // system clock
  input  wire logic             ce,       // clock enable
  input  wire logic [WIDTH-1:0] d,        // asynchronous input
  output logic      [WIDTH-1:0] q         // synchronised output
);

  logic [WIDTH-1:0] meta_reg;  // first stage, read only by second
  logic [WIDTH-1:0] meta_next; // first stage next value
  logic [WIDTH-1:0] q_next;    // second stage next value

  // while enabled the first stage follows the input and the second stage follows the first
  always_comb begin
    meta_next = ce ? d : meta_reg;
    q_next    = ce ? meta_reg : q;
  end

  // both stages registered, no reset; two enabled edges fill them
  always_ff @(posedge clk_sys) begin
    meta_reg <= meta_next;
    q        <= q_next;
  end

endmodule : cbs_sync

// [clock_buffer_smbus_control_test.sv]
// self-checking bench for the smbus control block
module clock_buffer_smbus_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cbs_pkg::*;
  localparam logic [7:0] AW = 8'hDA;  // address 1101 101, write
  logic       clk_sys, rst, ce, scl, sda_low, sda, sda_out, sda_oe;
  logic [3:0] pins_n, out_run;
  cbs_mode_t  pll_mode;
  logic [1:0] swing_select;
  int         failures, comparisons, cycles;
  // open-drain data line with pull-up
  assign sda = (sda_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
  cbs_smbus_host host_u (.scl(scl), .sda_low(sda_low), .sda(sda));
  cbs_smbus_top dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pin(3'h5),
    .bandwidth_strap_pin(2'h1), .out_enable_pin_n(pins_n), .out_run(out_run),
    .pll_mode(pll_mode), .swing_select(swing_select));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // block write: index, count, data, then stop
  task automatic wr(input logic [7:0] adr, input logic [7:0] d[$], input logic ok);
    logic a;
    host_u.start();
    host_u.put_byte(adr, a);
    check({7'h0, a}, {7'h0, ok});
    foreach (d[i]) begin
      if (ok) begin
        host_u.put_byte(d[i], a);
        check({7'h0, a}, 8'h01);
      end
    end
    host_u.stop();
  endtask : wr
  // block read from index n, count byte first
  task automatic rd(input logic [7:0] n, input logic [7:0] exp[$]);
    logic       a;
    logic [7:0] b;
    host_u.start();
    host_u.put_byte(AW, a);
    host_u.put_byte(n, a);
    host_u.start();
    host_u.put_byte(AW | 8'h01, a);
    check({7'h0, a}, 8'h01);
    host_u.get_byte(b, 1'b0);
    check(b, 8'h02);
    foreach (exp[i]) begin
      host_u.get_byte(b, i == exp.size() - 1);
      check(b, exp[i]);
    end
    host_u.stop();
  endtask : rd
  task automatic outs(input logic [3:0] r, input logic [1:0] m, input logic [1:0] s);
    check({4'h0, out_run}, {4'h0, r});
    check({6'h0, pll_mode}, {6'h0, m});
    check({6'h0, swing_select}, {6'h0, s});
  endtask : outs
  task automatic t_power_up();
    rd(8'h00, '{8'h5A, 8'h46});
    outs(4'h5, 2'h1, 2'h2);
    $display("done power_up");
  endtask : t_power_up
  task automatic t_masks();
    wr(AW, '{8'h00, 8'h02, 8'hFF, 8'hFF}, 1'b1);
    rd(8'h00, '{8'h5A, 8'h7F});
    outs(4'h5, 2'h3, 2'h3);
    $display("done masks");
  endtask : t_masks
  task automatic t_codes();
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      wr(AW, '{8'h01, 8'h01, {3'h0, k, 1'b0, k}}, 1'b1);
      outs(4'h5, 2'h1, k);
      wr(AW, '{8'h01, 8'h01, {3'h1, k, 1'b0, k}}, 1'b1);
      outs(4'h5, k, k);
    end
    $display("done codes");
  endtask : t_codes
  task automatic t_park();
    wr(AW, '{8'h00, 8'h01, 8'h08}, 1'b1);
    pins_n = 4'h0;
    repeat (6) @(posedge clk_sys);
    #1 outs(4'h2, 2'h3, 2'h3);
    wr(AW, '{8'h00, 8'h01, 8'h5A}, 1'b1);
    outs(4'hF, 2'h3, 2'h3);
    pins_n = 4'hA;
    $display("done park");
  endtask : t_park
  task automatic t_refuse_index();
    wr(8'hD8, '{8'h01}, 1'b0);
    wr(8'h5A, '{8'h01}, 1'b0);
    wr(AW, '{8'h01, 8'h02}, 1'b1);
    wr(AW, '{8'h01, 8'h02, 8'h01, 8'hFF}, 1'b1);
    rd(8'h01, '{8'h45, 8'h00});
    $display("done refuse_index");
  endtask : t_refuse_index
  // clock enable low freezes the pin path; three edges would pass a pin
  task automatic t_freeze();
    ce = 1'b0;
    pins_n = 4'h5;
    repeat (3) @(posedge clk_sys);
    #1 outs(4'h5, 2'h1, 2'h1);
    ce = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 outs(4'hA, 2'h1, 2'h1);
    $display("done freeze");
  endtask : t_freeze
  task automatic wrap_up();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pins_n = 4'hA;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 t_power_up();
    t_masks();
    t_codes();
    t_park();
    t_refuse_index();
    t_freeze();
    wrap_up();
  end
endmodule : clock_buffer_smbus_control_test
